/* File: slpd_top.sv */
// Purpose: Manual and automatic powerdown control of a serial line transceiver
// Assumes: Pins asynchronous to sys_clk, APB slave with zero wait states
// Notes:   Analog pump and comparators are outside; this drives the pump enable and reads the comparators
`timescale 1ns/1ps

module slpd_top #(
	parameter int NUM_TX     = 4,
	parameter int NUM_RX     = 4,
	parameter int IDLE_TICKS = slpd_pkg::IDLE_TICKS
) (
	input  wire logic              sys_clk,
	input  wire logic              rst,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              hold_awake_in,
	input  wire logic              shutdown_n_in,
	input  wire logic [NUM_TX-1:0] tx_data_in,
	input  wire logic [NUM_RX-1:0] rx_line_in,
	input  wire logic [NUM_RX-1:0] rx_valid_in,
	input  wire logic              supply_ok_in,
	output logic                   pump_en_out,
	output logic                   tx_oe_out,
	output logic                   rx_oe_out,
	output logic                   ready_out,
	output logic                   invalid_n_out
);

	localparam int NUM_ACT = NUM_TX + NUM_RX;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [2:0]           pin_level;
	logic [2:0]           pin_changed;
	logic [NUM_ACT-1:0]   act_level;
	logic [NUM_ACT-1:0]   act_changed;
	logic [NUM_RX-1:0]    valid_level;
	logic                 tick;
	logic                 hold_awake;
	logic                 shutdown_n;
	logic                 supply_ok;
	logic                 hold_fall;
	logic                 activity;
	logic                 all_invalid;
	logic [31:0]          idle_cnt;
	logic                 idle_expired;
	slpd_pkg::slpd_mode_t mode;
	slpd_pkg::slpd_mode_t next_mode;
	logic                 powered;
	logic [11:0]          wake_cnt;
	logic                 wake_done;
	logic [11:0]          wake_last;
	logic [7:0]           inv_cnt;
	logic [7:0]           val_cnt;
	slpd_pkg::slpd_ctrl_t ctrl;
	slpd_pkg::slpd_status_t status;
	logic                 apb_setup;
	logic                 apb_write;
	logic                 addr_hit;

	// ----------------------------------------------------------------
	// Synchronisers and prescaler
	// ----------------------------------------------------------------
	// control pins and supply comparator, three stages
	slpd_sync #(
		.W (3)
	) u_pin_sync (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.async_in ({supply_ok_in, shutdown_n_in, hold_awake_in}),
		.level    (pin_level),
		.changed  (pin_changed)
	);

	slpd_sync #(
		.W (NUM_ACT)
	) u_act_sync (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.async_in ({rx_line_in, tx_data_in}),
		.level    (act_level),
		.changed  (act_changed)
	);

	slpd_sync #(
		.W (NUM_RX)
	) u_valid_sync (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.async_in (rx_valid_in),
		.level    (valid_level),
		.changed  ()
	);

	// one microsecond enable for slow timers
	slpd_tick #(
		.DIV (slpd_pkg::TICK_CYC)
	) u_tick (
		.sys_clk (sys_clk),
		.rst     (rst),
		.tick    (tick)
	);

	assign hold_awake  = pin_level[0];
	assign shutdown_n  = pin_level[1];
	assign supply_ok   = pin_level[2];
	assign hold_fall   = pin_changed[0] & ~pin_level[0];
	assign activity    = |act_changed;
	assign all_invalid = ~|valid_level;

	// ----------------------------------------------------------------
	// Inactivity timer
	// ----------------------------------------------------------------
	// Priority: shutdown, then hold, then activity, then the hold falling edge, then the count
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			idle_cnt     <= '0;
			idle_expired <= slpd_pkg::EXPIRED_RST;
		end else if (!shutdown_n) begin
			// manual powerdown leaves the timer expired
			idle_expired <= 1'b1;
			idle_cnt     <= '0;
		end else if (hold_awake) begin
			// count held off while forced on
			idle_expired <= 1'b0;
			idle_cnt     <= '0;
		end else if (activity) begin
			idle_expired <= 1'b0;
			idle_cnt     <= '0;
		end else if (hold_fall) begin
			// count runs again from the falling edge
			idle_expired <= 1'b0;
			idle_cnt     <= '0;
		end else if (tick && !idle_expired) begin
			if (idle_cnt >= 32'(IDLE_TICKS - 1)) begin
				idle_expired <= 1'b1;
			end else begin
				idle_cnt <= idle_cnt + 32'h0000_0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// Power mode
	// ----------------------------------------------------------------
	always_comb begin
		if (!shutdown_n) begin
			next_mode = slpd_pkg::MODE_MANUAL_DOWN;
		end else if (hold_awake) begin
			next_mode = slpd_pkg::MODE_FORCED_ON;
		end else if (idle_expired) begin
			// leaving manual down with hold low needs a transition
			next_mode = slpd_pkg::MODE_AUTO_DOWN;
		end else begin
			// automatic mode only with hold low and shutdown high
			next_mode = slpd_pkg::MODE_AUTO_ON;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mode <= slpd_pkg::MODE_MANUAL_DOWN;
		end else begin
			mode <= next_mode;
		end
	end

	always_comb begin
		case (mode)
			slpd_pkg::MODE_FORCED_ON: begin
				powered = 1'b1;
			end
			slpd_pkg::MODE_AUTO_ON: begin
				powered = 1'b1;
			end
			default: begin
				powered = 1'b0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Wake-up timing
	// ----------------------------------------------------------------
	// Supply comparator may lag; the count bounds the exit time
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wake_cnt  <= '0;
			wake_done <= 1'b0;
		end else if (!powered) begin
			wake_cnt  <= '0;
			wake_done <= 1'b0;
		end else if (!wake_done) begin
			// transmitters enabled no later than the exit time
			if (wake_cnt == 12'(slpd_pkg::WAKE_CYC - 1) || supply_ok) begin
				wake_done <= 1'b1;
			end else begin
				wake_cnt <= wake_cnt + 12'h001;
			end
		end
	end

	// Latency of the last wake-up, for software
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wake_last <= '0;
		end else if (powered && !wake_done &&
				(wake_cnt == 12'(slpd_pkg::WAKE_CYC - 1) || supply_ok)) begin
			wake_last <= wake_cnt;
		end
	end

	// ----------------------------------------------------------------
	// Pin outputs
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pump_en_out <= 1'b0;
			tx_oe_out   <= 1'b0;
			rx_oe_out   <= 1'b1;
			ready_out   <= 1'b0;
		end else begin
			// pump stops in every powerdown mode
			pump_en_out <= powered;
			// transmitters released until the pump is back
			tx_oe_out   <= powered && (wake_done || supply_ok);
			// receivers off in manual down on monitor variants
			rx_oe_out   <= !(mode == slpd_pkg::MODE_MANUAL_DOWN && ctrl.monitor_en);
			// ready only while up and the supply is reached
			ready_out   <= ctrl.ready_en && powered && supply_ok;
		end
	end

	// ----------------------------------------------------------------
	// Invalid level detector
	// ----------------------------------------------------------------
	// runs regardless of mode and never feeds the power logic
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			inv_cnt       <= '0;
			val_cnt       <= '0;
			invalid_n_out <= slpd_pkg::INVALID_N_RST;
		end else if (all_invalid) begin
			val_cnt <= '0;
			// low once every receiver is invalid long enough
			if (inv_cnt == 8'(slpd_pkg::INV_TICKS)) begin
				invalid_n_out <= 1'b0;
			end else if (tick) begin
				inv_cnt <= inv_cnt + 8'h01;
			end
		end else begin
			inv_cnt <= '0;
			// high a microsecond after any valid receiver
			if (val_cnt == 8'(slpd_pkg::VALID_CYC - 1)) begin
				invalid_n_out <= 1'b1;
			end else begin
				val_cnt <= val_cnt + 8'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	// Zero wait states; read data is latched in the setup cycle
	assign pready    = 1'b1;
	assign apb_setup = psel && !penable;
	assign apb_write = psel && penable && pwrite;

	always_comb begin
		if (paddr == slpd_pkg::CTRL_ADDR) begin
			addr_hit = 1'b1;
		end else if (paddr == slpd_pkg::STATUS_ADDR) begin
			addr_hit = 1'b1;
		end else if (paddr == slpd_pkg::IDLE_ADDR) begin
			addr_hit = 1'b1;
		end else if (paddr == slpd_pkg::WAKE_ADDR) begin
			addr_hit = 1'b1;
		end else if (paddr == slpd_pkg::PINS_ADDR) begin
			addr_hit = 1'b1;
		end else begin
			addr_hit = 1'b0;
		end
	end

	assign pslverr = psel && penable && !addr_hit;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrl <= slpd_pkg::CTRL_RST;
		end else if (apb_write && paddr == slpd_pkg::CTRL_ADDR && pstrb[0]) begin
			ctrl <= pwdata[1:0];
		end
	end

	always_comb begin
		status.ready        = ready_out;
		status.tx_oe        = tx_oe_out;
		status.supply_ok    = supply_ok;
		status.invalid_n    = invalid_n_out;
		status.idle_expired = idle_expired;
		status.mode         = mode;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			prdata <= '0;
		end else if (apb_setup && !pwrite) begin
			if (paddr == slpd_pkg::CTRL_ADDR) begin
				prdata <= {30'h0, ctrl};
			end else if (paddr == slpd_pkg::STATUS_ADDR) begin
				prdata <= {23'h0, status};
			end else if (paddr == slpd_pkg::IDLE_ADDR) begin
				prdata <= idle_cnt;
			end else if (paddr == slpd_pkg::WAKE_ADDR) begin
				prdata <= {20'h0, wake_last};
			end else if (paddr == slpd_pkg::PINS_ADDR) begin
				prdata <= {30'h0, shutdown_n, hold_awake};
			end else begin
				prdata <= '0;
			end
		end
	end

endmodule // slpd_top

/* File: slpd_pkg.sv */
// Purpose: Shared constants and types of the serial line powerdown block
// Assumes: sys_clk at 25 MHz, APB register access
// Notes:   Times are kept in their own unit, counts derive from them
package slpd_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ      = 25_000_000;
	localparam int CLK_MHZ     = CLK_HZ / 1_000_000;
	localparam int TICK_US     = 1;
	localparam int TICK_CYC    = TICK_US * CLK_MHZ;
	localparam int IDLE_S      = 30;
	localparam int IDLE_TICKS  = IDLE_S * 1_000_000 / TICK_US;
	localparam int INV_US      = 30;
	// More than the figure: one tick beyond, as phase is unknown
	localparam int INV_TICKS   = INV_US / TICK_US + 1;
	localparam int VALID_NS    = 1000;
	localparam int VALID_CYC   = VALID_NS * CLK_MHZ / 1000;
	localparam int WAKE_US     = 100;
	localparam int WAKE_CYC    = WAKE_US * CLK_MHZ;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [11:0] CTRL_ADDR   = 12'h000;
	localparam logic [11:0] STATUS_ADDR = 12'h004;
	localparam logic [11:0] IDLE_ADDR   = 12'h008;
	localparam logic [11:0] WAKE_ADDR   = 12'h00c;
	localparam logic [11:0] PINS_ADDR   = 12'h010;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] CTRL_RST      = 2'h3;
	localparam logic       INVALID_N_RST = 1'b1;
	localparam logic       EXPIRED_RST   = 1'b0;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		MODE_FORCED_ON   = 4'b0001,
		MODE_AUTO_ON     = 4'b0010,
		MODE_AUTO_DOWN   = 4'b0100,
		MODE_MANUAL_DOWN = 4'b1000
	} slpd_mode_t;

	typedef struct packed {
		logic ready_en;
		logic monitor_en;
	} slpd_ctrl_t;

	typedef struct packed {
		logic       ready;
		logic       tx_oe;
		logic       supply_ok;
		logic       invalid_n;
		logic       idle_expired;
		slpd_mode_t mode;
	} slpd_status_t;

endpackage

/* File: slpd_sync.sv */
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Inputs asynchronous to sys_clk
// Notes:   A change counts once stages two and three agree
`timescale 1ns/1ps
module slpd_sync #(
	parameter int W = 1
) (
	input  wire logic         sys_clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] level,
	output logic      [W-1:0] changed
);

	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;

	// ----------------------------------------------------------------
	// Capture chain
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end else begin
			stage1 <= async_in;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// ----------------------------------------------------------------
	// Agreement and change pulse
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			level   <= '0;
			changed <= '0;
		end else begin
			for (int i = 0; i < W; i++) begin
				changed[i] <= 1'b0;
				if (stage2[i] == stage3[i] && stage3[i] != level[i]) begin
					level[i]   <= stage3[i];
					changed[i] <= 1'b1;
				end
			end
		end
	end

endmodule // slpd_sync

/* File: slpd_tick.sv */
// Purpose: Prescaler giving a one-cycle enable pulse
// Assumes: DIV of at least two
// Notes:   Idle and invalid timing in the block runs from this pulse; wake and valid counts run on sys_clk
`timescale 1ns/1ps
module slpd_tick #(
	parameter int DIV = slpd_pkg::TICK_CYC
) (
	input  wire logic sys_clk,
	input  wire logic rst,
	output logic      tick
);

	logic [15:0] count;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			count <= '0;
			tick  <= 1'b0;
		end else if (count == 16'(DIV - 1)) begin
			count <= '0;
			tick  <= 1'b1;
		end else begin
			count <= count + 16'h0001;
			tick  <= 1'b0;
		end
	end

endmodule // slpd_tick

/* File: slpd_top_chk.sv */
// Purpose: Port assertions for the powerdown block
// Assumes: One clock domain, reset active high
// Notes:   Pin paths add three to six edges of synchroniser delay
`timescale 1ns/1ps
module slpd_top_chk #(
	parameter int NUM_TX     = 4,
	parameter int NUM_RX     = 4,
	parameter int IDLE_TICKS = slpd_pkg::IDLE_TICKS
) (
	input wire logic              sys_clk,
	input wire logic              rst,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic [11:0]       paddr,
	input wire logic              pslverr,
	input wire logic              hold_awake_in,
	input wire logic              shutdown_n_in,
	input wire logic [NUM_TX-1:0] tx_data_in,
	input wire logic [NUM_RX-1:0] rx_line_in,
	input wire logic [NUM_RX-1:0] rx_valid_in,
	input wire logic              pump_en_out,
	input wire logic              tx_oe_out,
	input wire logic              ready_out,
	input wire logic              invalid_n_out
);
	localparam int WAKE_MAX = 2505;
	localparam int IDLE_MIN = (IDLE_TICKS - 1) * slpd_pkg::TICK_CYC;
	localparam int INV_MIN  = slpd_pkg::INV_US * slpd_pkg::CLK_MHZ;
	// ----------------------------------------------------------------
	// Activity and level counters
	// ----------------------------------------------------------------
	logic [NUM_TX-1:0] tx_q;
	logic [NUM_RX-1:0] rx_q;
	int                act_cnt;
	int                inv_cnt;
	int                vld_cnt;
	int                wake_wait;
	// Exit time too long for a delay range, so it is counted here
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tx_q      <= '0;
			rx_q      <= '0;
			act_cnt   <= 0;
			inv_cnt   <= 0;
			vld_cnt   <= 0;
			wake_wait <= 0;
		end else begin
			wake_wait <= (pump_en_out && !tx_oe_out) ? wake_wait + 1 : 0;
			tx_q    <= tx_data_in;
			rx_q    <= rx_line_in;
			act_cnt <= (tx_q != tx_data_in || rx_q != rx_line_in || hold_awake_in) ? 0 : act_cnt + 1;
			inv_cnt <= (rx_valid_in == '0) ? inv_cnt + 1 : 0;
			vld_cnt <= (|rx_valid_in) ? vld_cnt + 1 : 0;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence seq_shut_low;
		!shutdown_n_in [*8];
	endsequence
	sequence seq_both_high;
		(hold_awake_in && shutdown_n_in) [*8];
	endsequence
	chk_shut_wins: assert property (seq_shut_low |=> !pump_en_out)
		else $error("pump on with shutdown held low");
	chk_down_quiet: assert property (!pump_en_out |-> !tx_oe_out && !ready_out)
		else $error("transmitter or ready active with pump off");
	chk_hold_on: assert property (seq_both_high |=> pump_en_out)
		else $error("pump off with both controls high");
	chk_auto_idle: assert property ($fell(pump_en_out) && shutdown_n_in && $past(shutdown_n_in, 8)
		|-> act_cnt >= IDLE_MIN)
		else $error("automatic powerdown before idle time");
	chk_invalid_qual: assert property ($fell(invalid_n_out) |-> inv_cnt > INV_MIN)
		else $error("invalid flagged too early");
	chk_valid_rel: assert property (vld_cnt == 40 |-> invalid_n_out)
		else $error("invalid not released after valid level");
	chk_wake_time: assert property (wake_wait <= WAKE_MAX)
		else $error("transmitters late after wake");
	chk_apb_err: assert property (psel && penable && paddr >= 12'h014 |-> pslverr)
		else $error("no error on unmapped access");
endmodule // slpd_top_chk

bind slpd_top slpd_top_chk #(.NUM_TX(NUM_TX), .NUM_RX(NUM_RX), .IDLE_TICKS(IDLE_TICKS)) u_chk (
	.sys_clk, .rst, .psel, .penable, .paddr, .pslverr, .hold_awake_in, .shutdown_n_in,
	.tx_data_in, .rx_line_in, .rx_valid_in, .pump_en_out, .tx_oe_out, .ready_out, .invalid_n_out
);

/* File: slpd_host.sv */
// Purpose: Host power-management logic driving the two control pins
// Assumes: scheme 0 direct, 1 invalid to both, 2 one shutdown line, 3 hybrid
// Notes:   Pulse of eight cycles, long enough for the pin synchroniser
`timescale 1ns/1ps
module slpd_host (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic [1:0] scheme,
	input  wire logic       ctl_hold,
	input  wire logic       ctl_shut_n,
	input  wire logic       invalid_n,
	output logic            hold_awake,
	output logic            shutdown_n
);
	logic       src;
	logic       src_q;
	logic [3:0] pulse;
	assign src = scheme[0] ? invalid_n : ctl_shut_n;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			src_q <= 1'b1;
			pulse <= 4'h0;
		end else begin
			src_q <= src;
			pulse <= (src && !src_q) ? 4'h8 : (pulse != 4'h0) ? pulse - 4'h1 : 4'h0;
		end
	end
	always_comb begin
		shutdown_n = src;
		case (scheme)
			2'h0: hold_awake = ctl_hold;
			2'h3: hold_awake = (pulse != 4'h0);
			default: hold_awake = src;
		endcase
	end
endmodule // slpd_host

/* File: slpd_bench.sv */
// Purpose: Self-checking bench for the powerdown block
// Assumes: Short idle count, host model on the control pins
// Notes:   Outputs sampled at edges, before that edge's updates
`timescale 1ns/1ps
module slpd_bench;
	localparam int IDLE = 50;
	localparam int TK   = slpd_pkg::TICK_CYC;
	logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [3:0]  pstrb, tx_data_in, rx_line_in, rx_valid_in;
	logic        supply_ok_in, hold_awake_in, shutdown_n_in, ctl_hold, ctl_shut;
	logic        pump_en_out, tx_oe_out, rx_oe_out, ready_out, invalid_n_out;
	logic [1:0]  scheme;
	int          miscompares, comparisons, rnd;
	slpd_top #(.IDLE_TICKS(IDLE)) DUT (
		.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
		.pslverr, .hold_awake_in, .shutdown_n_in, .tx_data_in, .rx_line_in, .rx_valid_in,
		.supply_ok_in, .pump_en_out, .tx_oe_out, .rx_oe_out, .ready_out, .invalid_n_out
	);
	slpd_host u_host (
		.sys_clk, .rst, .scheme, .ctl_hold, .ctl_shut_n(ctl_shut), .invalid_n(invalid_n_out),
		.hold_awake(hold_awake_in), .shutdown_n(shutdown_n_in)
	);
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	// ----------------------------------------------------------------
	// Tasks and reference model
	// ----------------------------------------------------------------
	function automatic logic model_on(input int hold, input int shut, input int idle);
		return shut != 0 && (hold != 0 || idle < IDLE);
	endfunction
	function automatic logic sig(input int sel);
		return (sel == 0) ? pump_en_out : (sel == 1) ? invalid_n_out : tx_oe_out;
	endfunction
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic finish_test();
		$display("miscompares %0d comparisons %0d", miscompares, comparisons);
		if (miscompares == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// Bounded wait, a used-up bound ends the run
	task automatic wait_for(input int sel, input logic v, input int bound);
		int n;
		n = 0;
		while (sig(sel) !== v && n < bound) begin
			@(posedge sys_clk);
			n++;
		end
		check("wait", sig(sel), v);
		if (sig(sel) !== v) finish_test();
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		check("pready", pready, 1'b1);
		if (pready !== 1'b1) finish_test();
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x, input logic xe);
		apb(1'b0, a, 32'h0);
		check("prdata", q & m, x);
		check("pslverr", e, xe);
	endtask
	initial begin
		cyc(100000);
		miscompares++;
		finish_test();
	end
	initial begin
		rnd = $urandom(32'h8db4cf7f);
		{rst, ctl_hold, ctl_shut, supply_ok_in, pstrb, rx_valid_in} = {4'hf, 8'hff};
		{psel, penable, pwrite, paddr, pwdata, tx_data_in, rx_line_in, scheme} = '0;
		miscompares = 0;
		comparisons = 0;
		cyc(4);
		rst <= 1'b0;
		cyc(10);
		rd(slpd_pkg::CTRL_ADDR, 32'hffffffff, 32'h3, 1'b0);
		apb(1'b1, slpd_pkg::CTRL_ADDR, 32'h1);
		rd(slpd_pkg::CTRL_ADDR, 32'h3, 32'h1, 1'b0);
		rd(12'h020, 32'hffffffff, 32'h0, 1'b1);
		rd(slpd_pkg::STATUS_ADDR, 32'hf, 32'(slpd_pkg::MODE_FORCED_ON), 1'b0);
		cyc(2 * IDLE * TK);
		check("pump", pump_en_out, model_on(1, 1, 2 * IDLE));
		check("ready", ready_out, 1'b0);
		apb(1'b1, slpd_pkg::CTRL_ADDR, 32'h3);
		cyc(3);
		check("ready", ready_out, 1'b1);
		ctl_shut <= 1'b0;
		wait_for(0, model_on(1, 0, 0), 20);
		check("tx_oe", tx_oe_out, 1'b0);
		check("rx_oe", rx_oe_out, 1'b0);
		tx_data_in <= tx_data_in ^ 4'($urandom_range(15, 1));
		cyc(20);
		check("pump", pump_en_out, 1'b0);
		ctl_hold <= 1'b0;
		cyc(10);
		ctl_shut <= 1'b1;
		cyc(40);
		rd(slpd_pkg::STATUS_ADDR, 32'hf, 32'(slpd_pkg::MODE_AUTO_DOWN), 1'b0);
		supply_ok_in <= 1'b0;
		tx_data_in <= tx_data_in ^ 4'($urandom_range(15, 1));
		wait_for(0, 1'b1, 20);
		ctl_hold <= 1'b1;
		check("tx_oe", tx_oe_out, 1'b0);
		wait_for(2, 1'b1, 2600);
		check("ready", ready_out, 1'b0);
		supply_ok_in <= 1'b1;
		cyc(10);
		check("ready", ready_out, 1'b1);
		ctl_hold <= 1'b0;
		cyc((IDLE - 2) * TK);
		check("pump", pump_en_out, model_on(0, 1, IDLE - 2));
		wait_for(0, model_on(0, 1, IDLE), 6 * TK);
		rx_line_in <= rx_line_in ^ 4'($urandom_range(15, 1));
		wait_for(0, 1'b1, 20);
		ctl_hold <= 1'b1;
		rx_valid_in <= 4'h0;
		cyc(700);
		check("invalid_n", invalid_n_out, 1'b1);
		wait_for(1, 1'b0, 150);
		check("pump", pump_en_out, 1'b1);
		rx_valid_in <= 4'h1 << $urandom_range(3, 0);
		cyc(20);
		check("invalid_n", invalid_n_out, 1'b0);
		wait_for(1, 1'b1, 30);
		scheme <= 2'h1;
		rx_valid_in <= 4'h0;
		wait_for(0, 1'b0, 900);
		rx_valid_in <= 4'h8;
		wait_for(0, 1'b1, 60);
		scheme <= 2'h2;
		ctl_shut <= 1'b0;
		wait_for(0, 1'b0, 20);
		ctl_shut <= 1'b1;
		wait_for(0, 1'b1, 20);
		scheme <= 2'h3;
		rx_valid_in <= 4'h0;
		wait_for(0, 1'b0, 900);
		rx_valid_in <= 4'h2;
		wait_for(0, 1'b1, 60);
		finish_test();
	end
endmodule // slpd_bench
